/* verification/pcm_chk.sv */
`timescale 1ns/100ps
module pcm_chk (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic [31:0] wb_dat_out,
	input wire logic wb_ack_out,
	input wire logic preload_enable_in,
	input wire logic dev_clk_pin_in,
	input wire logic serial_state_out,
	input wire logic serial_state_oe_out,
	input wire logic [7:0] mc_pin_out
);
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	chk_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack too long");
	chk_ack_req: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("ack missing");
	chk_ack_cause: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
		else $error("ack without request");
	chk_dat_idle: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
		else $error("data outside ack");
	chk_drain_low: assert property (serial_state_out == 1'b0)
		else $error("serial line driven high");
	chk_oe_idle: assert property (!preload_enable_in [*2] |-> !serial_state_oe_out)
		else $error("line pulled outside preload");
	chk_oe_cause: assert property ($rose(serial_state_oe_out) |-> $past(preload_enable_in))
		else $error("pull without preload");
	// Writes are masked out because a new configuration may move the pins.
	chk_pins_hold: assert property (
		(!wb_cyc_in && $stable(dev_clk_pin_in)) [*3] |=> $stable(mc_pin_out))
		else $error("pins moved without a clock");
endmodule : pcm_chk
bind pcm_core pcm_chk pcm_chk_inst (.*);

/* verification/pcm_tester.sv */
`timescale 1ns/100ps
module pcm_tester #(
	parameter int WAIT = 8
) (
	input wire logic clk_in,
	input wire logic serial_state_out,
	input wire logic serial_state_oe_out,
	output logic enable_out,
	output logic data_out,
	output logic sclk_out
);
	// The tester owns the pull-up, so a released line reads high.
	wire logic line = serial_state_oe_out ? serial_state_out : 1'b1;
	initial begin
		enable_out = 1'b0;
		data_out = 1'b0;
		sclk_out = 1'b0;
	end
	task automatic settle;
		repeat (WAIT + 2) @(posedge clk_in);
	endtask : settle
	task automatic enter;
		@(posedge clk_in);
		enable_out <= 1'b1;
		repeat (2) @(posedge clk_in);
	endtask : enter
	task automatic leave;
		@(posedge clk_in);
		enable_out <= 1'b0;
		data_out <= ~data_out;
	endtask : leave
	// The line is read before the new bit goes in, after the last shift settled.
	task automatic shift(input logic d, output logic q);
		@(negedge clk_in);
		q = line;
		@(posedge clk_in);
		data_out <= d;
		sclk_out <= 1'b1;
		@(posedge clk_in);
		sclk_out <= 1'b0;
		@(posedge clk_in);
	endtask : shift
endmodule : pcm_tester

/* verification/test_pcm_core.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin \
	n_checks++; \
	if ((g) !== (e)) begin \
		num_errors++; \
		$display("BAD %0t got %h want %h", $time, g, e); \
	end \
end
module test_pcm_core;
	import pcm_pkg::*;
	localparam int PU = 8;
	logic clk_in, rst_n_in, req, wb_we_in, wb_ack_out, o, out_enable_n_pin_in;
	logic [3:0] wb_adr_in;
	logic [31:0] wb_dat_in, wb_dat_out, rdat;
	logic preload_enable_in, serial_preload_in, dev_clk_pin_in;
	logic serial_state_out, serial_state_oe_out;
	logic [7:0] mc_pin_out, mc_pin_oe_out;
	int num_errors, n_checks;
	pcm_core #(.POWER_UP_RESET_CYCLES(PU)) pcm_core_inst (
		.wb_cyc_in(req),
		.wb_stb_in(req),
		.wb_sel_in(4'hf),
		.*
	);
	pcm_tester #(.WAIT(PU)) pcm_tester_inst (
		.clk_in(clk_in),
		.serial_state_out(serial_state_out),
		.serial_state_oe_out(serial_state_oe_out),
		.enable_out(preload_enable_in),
		.data_out(serial_preload_in),
		.sclk_out(dev_clk_pin_in)
	);
	task automatic wrap_up;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_in);
		req <= 1'b1;
		wb_we_in <= w;
		wb_adr_in <= a;
		wb_dat_in <= d;
		do begin
			@(posedge clk_in);
			n++;
		end while (wb_ack_out !== 1'b1 && n < 20);
		rdat = wb_dat_out;
		req <= 1'b0;
		if (wb_ack_out !== 1'b1) begin
			num_errors++;
			wrap_up();
		end
	endtask : wb
	task automatic rd(input logic [3:0] a);
		wb(1'b0, a, 32'h0);
	endtask : rd
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	initial begin
		logic [7:0] pat;
		logic [7:0] exp;
		pat = 8'hbd;
		exp = 8'hd0;
		rst_n_in = 1'b0;
		req = 1'b0;
		wb_we_in = 1'b0;
		wb_adr_in = 4'h0;
		wb_dat_in = 32'h0;
		out_enable_n_pin_in = 1'b1;
		num_errors = 0;
		n_checks = 0;
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		rd(PCM_OFS_CONFIG);
		`CHK(rdat, 32'h0000_0002)
		rd(4'h2);
		`CHK(rdat, 32'h0)
		pcm_tester_inst.settle();
		// Polarity is set first; the chain must not see it.
		wb(1'b1, PCM_OFS_CONFIG, 32'h0030_5502);
		wb(1'b1, PCM_OFS_FUNC, 32'h0000_ff0f);
		rd(PCM_OFS_STATE);
		`CHK(rdat[15:8], 8'haa)
		pcm_tester_inst.enter();
		for (int i = 0; i < 8; i++) begin
			pcm_tester_inst.shift(pat[i], o);
			`CHK(o, exp[i])
		end
		pcm_tester_inst.leave();
		repeat (3) @(posedge clk_in);
		rd(PCM_OFS_STATE);
		`CHK(rdat[7:0] & 8'haa, 8'ha2)
		`CHK(mc_pin_out & 8'haa, 8'h08)
		`CHK(mc_pin_oe_out & 8'haa, 8'h00)
		out_enable_n_pin_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		`CHK(mc_pin_oe_out & 8'haa, 8'haa)
		pcm_tester_inst.shift(1'b0, o);
		rd(PCM_OFS_STATE);
		`CHK(rdat[7:0] & 8'haa, 8'h2a)
		wb(1'b1, PCM_OFS_CONFIG, 32'h0030_5503);
		wb(1'b1, PCM_OFS_FUNC, 32'h0000_fff0);
		pcm_tester_inst.shift(1'b0, o);
		rd(PCM_OFS_STATE);
		`CHK(rdat[15:0] & 16'hffaa, 16'h002a)
		wb(1'b1, PCM_OFS_CONFIG, 32'h0030_5500);
		repeat (3) @(posedge clk_in);
		`CHK(mc_pin_oe_out, 8'haa)
		`CHK(mc_pin_out & 8'haa, 8'h2a)
		wb(1'b1, PCM_OFS_CONFIG, 32'h0000_ff02);
		pcm_tester_inst.enter();
		pcm_tester_inst.shift(1'b0, o);
		pcm_tester_inst.shift(1'b1, o);
		`CHK(o, 1'b0)
		pcm_tester_inst.shift(1'b0, o);
		`CHK(o, 1'b1)
		wrap_up();
	end
endmodule : test_pcm_core

/* verilog/pcm_core.sv */
`timescale 1ns/100ps
// Summary of operation
// - Preload only while enable pin elevated.
// - One chain bit per registered macrocell.
// - Shift on rising edge of shift clock.
// - Data enters lowest pin, moves upward.
// - Old contents shift out on serial output.
// - Preload ignores output three-state control.
// - Low is 0; normal pins show inverted.
// - Polarity acts before the register input.
// - Serial output is open drain in preload.
// - Normal clocking resumes from loaded state.
// - Two global cells, two local per macrocell.
// - Sync cell set: purely combinatorial device.
// - Sync cell clear: clock and enable pins.
// - Global cell clear: local selects output/input.
// - Global cell set: local selects registered/combinatorial.
// - Polarity cell: 0 active low, 1 high.
// - Power-up clears every macrocell register.
module pcm_core
	import pcm_pkg::*;
#(
	parameter int unsigned POWER_UP_RESET_CYCLES = PCM_POWER_UP_RESET_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [3:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic preload_enable_in,
	input wire logic serial_preload_in,
	input wire logic dev_clk_pin_in,
	input wire logic out_enable_n_pin_in,
	output logic serial_state_out,
	output logic serial_state_oe_out,
	output logic [7:0] mc_pin_out,
	output logic [7:0] mc_pin_oe_out
);

	import pcm_pkg::*;

	pcm_cfg_s cfg_reg;
	logic [7:0] func_reg;
	logic [7:0] func_oe_reg;
	logic [7:0] q_reg;
	logic [7:0] q_next;
	logic [PCM_RST_CNT_W-1:0] rst_cnt_reg;
	logic busy_reg;
	logic ack_reg;
	logic [31:0] dat_reg;
	logic sout_oe_reg;
	logic [7:0] pin_reg;
	logic [7:0] pin_oe_reg;

	pcm_mc_mode_s mode;
	pcm_array_mode_e array_mode;
	logic clk_rise;
	logic preload_active;
	logic shift_step;
	logic normal_step;
	logic [8:0] chain;
	logic [7:0] reg_d;
	logic [7:0] pin_val;
	logic [7:0] pin_oe;
	logic wb_req;
	logic wb_wr;
	logic [31:0] rd_data;
	logic [31:0] wmask;

	localparam logic [PCM_RST_CNT_W-1:0] RST_LAST =
		PCM_RST_CNT_W'(POWER_UP_RESET_CYCLES - 1);

	pcm_mc_decode u_decode (
		.cfg_in(cfg_reg),
		.mode_out(mode),
		.array_mode_out(array_mode)
	);

	// The device clock pin doubles as the preload shift clock.
	pcm_edge u_clk_edge (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.level_in(dev_clk_pin_in),
		.rise_out(clk_rise)
	);

	// Power-up reset window; preload and clocking wait until it ends.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_cnt_reg <= '0;
			busy_reg <= 1'h1;
		end else if (busy_reg) begin
			if (rst_cnt_reg == RST_LAST) begin
				busy_reg <= 1'h0;
			end else begin
				rst_cnt_reg <= rst_cnt_reg + 1'h1;
			end
		end
	end

	// A preload attempted too early is ignored, as the tester must wait.
	assign preload_active = preload_enable_in & ~busy_reg;
	// Dropping the enable disconnects the shift path at once.
	assign shift_step = preload_active & clk_rise;
	// The sync cell clear makes the pin a register clock.
	assign normal_step = ~preload_active & ~busy_reg & ~cfg_reg.sync_mode_cell & clk_rise;

	// Each registered macrocell takes the nearest registered bit below it, or the serial input if there is none.
	// Non-registered cells pass the chain through untouched.
	assign chain[0] = serial_preload_in;
	genvar i;
	generate
		for (i = 0; i < PCM_NUM_MC; i++) begin : g_chain
			assign chain[i+1] = mode.registered[i] ? q_reg[i] : chain[i];
			// Polarity inverts the function ahead of the register.
			assign reg_d[i] = func_reg[i] ^ cfg_reg.polarity_cell[i];
			always_comb begin
				if (shift_step && mode.registered[i]) begin
					q_next[i] = chain[i];
				end else if (normal_step && mode.registered[i]) begin
					q_next[i] = reg_d[i];
				end else begin
					q_next[i] = q_reg[i];
				end
			end
			// Registered pins show the inverted state; others honour polarity.
			always_comb begin
				if (mode.registered[i]) begin
					pin_val[i] = ~q_reg[i];
					pin_oe[i] = ~out_enable_n_pin_in;
				end else begin
					pin_val[i] = ~reg_d[i];
					pin_oe[i] = mode.is_output[i] & func_oe_reg[i];
				end
			end
		end
	endgenerate

	// Registers clear at power-up; the state pins then read high.
	// Shifting works whatever the output enables say.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q_reg <= PCM_RST_Q;
		end else begin
			q_reg <= q_next;
		end
	end

	// Open drain: only pull low, else release to the tester pull-up.
	// With no registered cell the input passes straight through.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sout_oe_reg <= 1'h0;
		end else begin
			sout_oe_reg <= preload_active & ~chain[PCM_NUM_MC];
		end
	end

	assign serial_state_out = 1'h0;
	assign serial_state_oe_out = sout_oe_reg;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin_reg <= 8'h00;
			pin_oe_reg <= 8'h00;
		end else begin
			pin_reg <= pin_val;
			pin_oe_reg <= pin_oe;
		end
	end

	assign mc_pin_out = pin_reg;
	assign mc_pin_oe_out = pin_oe_reg;

	// Wishbone slave: one wait state, ack for one cycle.
	// A write lands on the edge where the master sees ack, so a dropped request stores nothing.
	assign wb_req = wb_cyc_in & wb_stb_in & ~ack_reg;
	assign wb_wr = wb_cyc_in & wb_stb_in & wb_we_in & ack_reg;
	assign wmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ack_reg <= 1'h0;
		end else begin
			ack_reg <= wb_req;
		end
	end

	// Two global and sixteen local cells, held in one word.
	// Medium array use needs all local cells set; software owns that.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_reg.sync_mode_cell <= PCM_RST_SYNC;
			cfg_reg.global_arch_cell <= PCM_RST_GLOBAL;
			cfg_reg.local_arch_cell <= PCM_RST_LOCAL;
			cfg_reg.polarity_cell <= PCM_RST_POL;
		end else if (wb_wr && wb_adr_in == PCM_OFS_CONFIG) begin
			if (wb_sel_in[0]) begin
				cfg_reg.sync_mode_cell <= wb_dat_in[PCM_CFG_SYNC_BIT];
				cfg_reg.global_arch_cell <= wb_dat_in[PCM_CFG_GLOBAL_BIT];
			end
			if (wb_sel_in[1]) begin
				cfg_reg.local_arch_cell <= wb_dat_in[PCM_CFG_LOCAL_LSB +: 8];
			end
			if (wb_sel_in[2]) begin
				cfg_reg.polarity_cell <= wb_dat_in[PCM_CFG_POL_LSB +: 8];
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			func_reg <= PCM_RST_FUNC;
			func_oe_reg <= PCM_RST_FUNC_OE;
		end else if (wb_wr && wb_adr_in == PCM_OFS_FUNC) begin
			if (wb_sel_in[0]) begin
				func_reg <= wb_dat_in[PCM_FUNC_VAL_LSB +: 8];
			end
			if (wb_sel_in[1]) begin
				func_oe_reg <= wb_dat_in[PCM_FUNC_OE_LSB +: 8];
			end
		end
	end

	// Unmapped offsets and unused bits read as zero.
	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (wb_adr_in)
			PCM_OFS_CONFIG: begin
				rd_data[PCM_CFG_SYNC_BIT] = cfg_reg.sync_mode_cell;
				rd_data[PCM_CFG_GLOBAL_BIT] = cfg_reg.global_arch_cell;
				rd_data[PCM_CFG_LOCAL_LSB +: 8] = cfg_reg.local_arch_cell;
				rd_data[PCM_CFG_POL_LSB +: 8] = cfg_reg.polarity_cell;
			end
			PCM_OFS_FUNC: begin
				rd_data[PCM_FUNC_VAL_LSB +: 8] = func_reg;
				rd_data[PCM_FUNC_OE_LSB +: 8] = func_oe_reg;
			end
			PCM_OFS_STATE: begin
				rd_data[PCM_ST_Q_LSB +: 8] = q_reg;
				rd_data[PCM_ST_REGMASK_LSB +: 8] = mode.registered;
				rd_data[PCM_ST_PRELOAD_BIT] = preload_active;
				rd_data[PCM_ST_BUSY_BIT] = busy_reg;
				rd_data[PCM_ST_CLKPIN_BIT] = dev_clk_pin_in;
				rd_data[PCM_ST_OEPIN_BIT] = out_enable_n_pin_in;
				rd_data[PCM_ST_SOUT_BIT] = ~sout_oe_reg;
			end
			PCM_OFS_PINS: begin
				rd_data[PCM_PIN_VAL_LSB +: 8] = pin_reg;
				rd_data[PCM_PIN_OE_LSB +: 8] = pin_oe_reg;
			end
			default: begin
				rd_data = 32'h0000_0000;
			end
		endcase
	end

	// Read data is masked by the byte selects so untouched lanes stay zero.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dat_reg <= 32'h0000_0000;
		end else if (wb_req && !wb_we_in) begin
			dat_reg <= rd_data & wmask;
		end else begin
			dat_reg <= 32'h0000_0000;
		end
	end

	assign wb_dat_out = dat_reg;
	assign wb_ack_out = ack_reg;

endmodule : pcm_core

/* verilog/pcm_edge.sv */
`timescale 1ns/100ps
module pcm_edge (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic level_in,
	output logic rise_out
);

	logic last_reg;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			last_reg <= 1'h0;
		end else begin
			last_reg <= level_in;
		end
	end

	// Pins are synchronous to clk_in, so one stored sample is enough.
	assign rise_out = level_in & ~last_reg;

endmodule : pcm_edge

/* verilog/pcm_mc_decode.sv */
`timescale 1ns/100ps
module pcm_mc_decode
	import pcm_pkg::*;
(
	input pcm_pkg::pcm_cfg_s cfg_in,
	output pcm_pkg::pcm_mc_mode_s mode_out,
	output pcm_pkg::pcm_array_mode_e array_mode_out
);

	always_comb begin
		if (cfg_in.sync_mode_cell) begin
			array_mode_out = PCM_COMB_ONLY;
		end else if (cfg_in.global_arch_cell) begin
			array_mode_out = PCM_REGISTERED_ARRAY;
		end else begin
			array_mode_out = PCM_SMALL_ARRAY;
		end
	end

	genvar i;
	generate
		for (i = 0; i < PCM_NUM_MC; i++) begin : g_mc
			// A purely combinatorial device has no registers at all.
			// Registered only with the global cell set and local cell clear.
			assign mode_out.registered[i] = ~cfg_in.sync_mode_cell & cfg_in.global_arch_cell
				& ~cfg_in.local_arch_cell[i];
			// In the small array mode a set local cell turns the pin into an input.
			assign mode_out.is_output[i] = cfg_in.global_arch_cell | ~cfg_in.local_arch_cell[i];
		end
	endgenerate

endmodule : pcm_mc_decode

/* verilog/pcm_pkg.sv */
package pcm_pkg;

	localparam int unsigned PCM_NUM_MC = 8;

	// Clock rate and the power-up register reset time.
	localparam int unsigned PCM_CLK_PERIOD_PS = 4000;
	localparam int unsigned PCM_POWER_UP_RESET_TIME_US = 45;
	localparam int unsigned PCM_POWER_UP_RESET_CYCLES =
		(PCM_POWER_UP_RESET_TIME_US * 1000000) / PCM_CLK_PERIOD_PS;
	localparam int unsigned PCM_RST_CNT_W = 16;

	// Register byte offsets.
	localparam logic [3:0] PCM_OFS_CONFIG = 4'h0;
	localparam logic [3:0] PCM_OFS_FUNC = 4'h4;
	localparam logic [3:0] PCM_OFS_STATE = 4'h8;
	localparam logic [3:0] PCM_OFS_PINS = 4'hc;

	// Configuration register fields.
	localparam int unsigned PCM_CFG_SYNC_BIT = 0;
	localparam int unsigned PCM_CFG_GLOBAL_BIT = 1;
	localparam int unsigned PCM_CFG_LOCAL_LSB = 8;
	localparam int unsigned PCM_CFG_POL_LSB = 16;

	// Function register fields.
	localparam int unsigned PCM_FUNC_VAL_LSB = 0;
	localparam int unsigned PCM_FUNC_OE_LSB = 8;

	// State register fields.
	localparam int unsigned PCM_ST_Q_LSB = 0;
	localparam int unsigned PCM_ST_REGMASK_LSB = 8;
	localparam int unsigned PCM_ST_PRELOAD_BIT = 16;
	localparam int unsigned PCM_ST_BUSY_BIT = 17;
	localparam int unsigned PCM_ST_CLKPIN_BIT = 18;
	localparam int unsigned PCM_ST_OEPIN_BIT = 19;
	localparam int unsigned PCM_ST_SOUT_BIT = 20;

	// Pin register fields.
	localparam int unsigned PCM_PIN_VAL_LSB = 0;
	localparam int unsigned PCM_PIN_OE_LSB = 8;

	// Values after reset.
	localparam logic PCM_RST_SYNC = 1'h0;
	localparam logic PCM_RST_GLOBAL = 1'h1;
	localparam logic [7:0] PCM_RST_LOCAL = 8'h00;
	localparam logic [7:0] PCM_RST_POL = 8'h00;
	localparam logic [7:0] PCM_RST_FUNC = 8'h00;
	localparam logic [7:0] PCM_RST_FUNC_OE = 8'h00;
	localparam logic [7:0] PCM_RST_Q = 8'h00;

	typedef struct packed {
		logic sync_mode_cell;
		logic global_arch_cell;
		logic [7:0] local_arch_cell;
		logic [7:0] polarity_cell;
	} pcm_cfg_s;

	typedef struct packed {
		logic [7:0] registered;
		logic [7:0] is_output;
	} pcm_mc_mode_s;

	typedef enum logic [1:0] {
		PCM_SMALL_ARRAY,
		PCM_REGISTERED_ARRAY,
		PCM_COMB_ONLY
	} pcm_array_mode_e;

endpackage : pcm_pkg
